// file: verilog/adc_ctrl_pkg.sv
// constants, field layouts and carrier types of the converter control block
// assumes a single 50 MHz master clock and an AHB-Lite master in front
//
// Behaviour
// (R1) host holds sync low at least four master clock cycles
// (R2) sync falling edge resets filter and modulator, held while sync low
// (R3) sync reset leaves every configuration register untouched
// (R4) after sync rises, sampling restarts on the following master clock edge; sample_start_q rises on the second edge after sync_rise
// (R5) host releases sync on a rising clock edge when sharing a clock
// (R6) sync rising edge starts conversion, ready falls when result is available
// (R7) first result after a restart waits four output-rate periods of settling
// (R8) parity bit makes the count of ones with the 24-bit result even
// (R9) host enables status appending whenever it enables parity
// (R10) host treats an odd count of ones as a corrupted read
// (R11) two-bit clock source field picks internal, crystal or external clock
// (R12) one clock source setting drives the internal oscillator out on the pin
// (R13) sensor-select bit routes the temperature sensor to the converter input
// (R14) general-purpose outputs are enabled in pairs, upper and lower
// (R15) each enabled output drives its own level bit
// (R16) reading output control returns sampled pin levels, not written levels
// (R17) a mode or configuration write resets modulator and filter like sync
// (R18) with status appending, data reads carry status byte with channel bits
// (R19) ready goes low on a new result and high once the data is read
// (R20) sync input passes a synchroniser before its edges are used
package adc_ctrl_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ    = 50000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned OSC_FREQ_KHZ    = 4920;
  localparam int unsigned OSC_HALF_CYCLES = (CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ) < 1) ? 1 :
                                            CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
  localparam int unsigned SYNC_MIN_CYCLES = 4;
  localparam int unsigned SETTLE_PERIODS  = 4;
  localparam int unsigned FS_UNIT_CLKS    = 1024;

  // ==========================================================================
  // register map
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] GPOCTL_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // mode word: [9:0] fs, [16] parity, [17] status append, [18] sel lo, [19] sel hi
  localparam int unsigned MODE_FS_LSB      = 0;
  localparam int unsigned MODE_PAR_BIT     = 16;
  localparam int unsigned MODE_APPEND_BIT  = 17;
  localparam int unsigned MODE_SEL_LO_BIT  = 18;
  localparam int unsigned MODE_SEL_HI_BIT  = 19;
  // config word: [3:0] channel, [16] temperature sensor select
  localparam int unsigned CFG_CHAN_LSB     = 0;
  localparam int unsigned CFG_TEMP_BIT     = 16;
  // output control word: [3:0] levels, [4] lower pair enable, [5] upper pair enable
  localparam int unsigned GPO_LVL_LSB      = 0;
  localparam int unsigned GPO_LO_EN_BIT    = 4;
  localparam int unsigned GPO_HI_EN_BIT    = 5;
  // status byte: [3:0] channel, [4] parity, [7] ready (low active)
  localparam int unsigned STAT_PAR_BIT     = 4;
  localparam int unsigned STAT_RDY_BIT     = 7;
  localparam int unsigned STAT_SYNC_BIT    = 8;
  localparam int unsigned STAT_SETTLE_BIT  = 9;

  localparam logic [9:0]  MODE_FS_RST = 10'h060;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    CLK_SRC_CRYSTAL = 2'b00,
    CLK_SRC_EXT     = 2'b01,
    CLK_SRC_INT     = 2'b10,
    CLK_SRC_INT_OUT = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_START  = 2'b01,
    ST_SETTLE = 2'b10,
    ST_RUN    = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  typedef struct packed {
    clk_src_t    clock_source_sel;
    logic        status_append;
    logic        parity_enable;
    logic [9:0]  fs_word;
  } mode_t;

  typedef struct packed {
    logic        temp_sensor_sel;
    logic [3:0]  channel;
  } config_t;

  typedef struct packed {
    logic        gpo_upper_pair_enable;
    logic        gpo_lower_pair_enable;
    logic [3:0]  gpo_level;
  } gpo_ctl_t;

  // odd parity of a 24-bit word: one when the count of ones is odd
  function automatic logic parity24(input logic [23:0] w);
    parity24 = ^w;
  endfunction : parity24

endpackage : adc_ctrl_pkg

// file: verilog/pin_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to hclk
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH   = 5,
  parameter logic [4:0]  RST_VAL = 5'h10
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_q
);
  import adc_ctrl_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= RST_VAL[WIDTH-1:0];
      s2_q <= RST_VAL[WIDTH-1:0];
      s3_q <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only when the two later stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_q <= RST_VAL[WIDTH-1:0];
    else
      for (int i = 0; i < WIDTH; i++)
        if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i]; // R20
  end

endmodule : pin_sync

// file: verilog/adc_sync_parity_gpo_control.sv
// sync handling, clock source selection, parity and general-purpose outputs
// assumes an AHB-Lite master, a filter core presenting result_data, one clock
`timescale 1ns/1ps
module adc_sync_parity_gpo_control #(
  parameter int unsigned CLKS_PER_FS_UNIT = adc_ctrl_pkg::FS_UNIT_CLKS
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire adc_ctrl_pkg::ahb_req_t ahb_req,
  input  wire logic [31:0]            hwdata,
  output adc_ctrl_pkg::ahb_rsp_t      ahb_rsp,
  input  wire logic                   sync_n_pin,
  input  wire logic [23:0]            result_data,
  input  wire logic [3:0]             gpo_pin_in,
  output logic                        filter_reset_q,
  output logic                        sample_start_q,
  output logic                        ready_n_q,
  output adc_ctrl_pkg::clk_src_t      clock_source_q,
  output logic                        crystal_osc_enable_q,
  output logic                        clock_io_out_q,
  output logic                        clock_io_oe_q,
  output logic                        temp_sensor_sel_q,
  output logic [3:0]                  gpo_out_q,
  output logic [3:0]                  gpo_oe_q
);
  import adc_ctrl_pkg::*;

  // ==========================================================================
  // input synchronisation
  logic [4:0]  pins_lvl;
  logic        sync_lvl;
  logic        sync_lvl_d1_q;
  logic [3:0]  gpo_in_lvl;

  pin_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h10)
  ) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({sync_n_pin, gpo_pin_in}),
    .level_q (pins_lvl)
  );

  assign sync_lvl   = pins_lvl[4];
  assign gpo_in_lvl = pins_lvl[3:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_lvl_d1_q <= 1'b1;
    else
      sync_lvl_d1_q <= sync_lvl;
  end

  logic sync_low;
  logic sync_rise;
  assign sync_low  = !sync_lvl;
  assign sync_rise = sync_lvl && !sync_lvl_d1_q;

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic        ap_valid;
  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;
  logic        rd_data_evt;
  logic        wr_mode;
  logic        wr_cfg;
  logic        wr_gpo;
  mode_t       mode_q;
  config_t     cfg_q;
  gpo_ctl_t    gpo_q;
  logic [23:0] data_q;
  logic [3:0]  data_chan_q;
  logic        data_par_q;
  conv_state_t state_q;
  logic [31:0] rd_word;

  assign ap_valid    = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  assign rd_data_evt = ap_valid && !ahb_req.hwrite && (ahb_req.haddr[7:0] == DATA_OFS);
  assign wr_mode     = wr_pend_q && (wr_ofs_q == MODE_OFS);
  assign wr_cfg      = wr_pend_q && (wr_ofs_q == CONFIG_OFS);
  assign wr_gpo      = wr_pend_q && (wr_ofs_q == GPOCTL_OFS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
    end
    else
    begin
      wr_pend_q <= ap_valid && ahb_req.hwrite;
      if (ap_valid)
        wr_ofs_q <= ahb_req.haddr[7:0];
    end
  end

  logic [7:0] status_byte;
  assign status_byte = {ready_n_q, 2'b00, data_par_q, data_chan_q};

  // read mux; the output control word shows sampled pin levels
  always_comb
  begin
    rd_word = WORD_ZERO;
    unique case (ahb_req.haddr[7:0])
      MODE_OFS:
      begin
        rd_word[MODE_FS_LSB +: 10] = mode_q.fs_word;
        rd_word[MODE_PAR_BIT]      = mode_q.parity_enable;
        rd_word[MODE_APPEND_BIT]   = mode_q.status_append;
        rd_word[MODE_SEL_LO_BIT]   = mode_q.clock_source_sel[0];
        rd_word[MODE_SEL_HI_BIT]   = mode_q.clock_source_sel[1];
      end
      CONFIG_OFS:
      begin
        rd_word[CFG_CHAN_LSB +: 4] = cfg_q.channel;
        rd_word[CFG_TEMP_BIT]      = cfg_q.temp_sensor_sel;
      end
      GPOCTL_OFS:
      begin
        rd_word[GPO_LVL_LSB +: 4]  = gpo_in_lvl; // R16
        rd_word[GPO_LO_EN_BIT]     = gpo_q.gpo_lower_pair_enable;
        rd_word[GPO_HI_EN_BIT]     = gpo_q.gpo_upper_pair_enable;
      end
      DATA_OFS:
      begin
        rd_word[23:0] = data_q;
        if (mode_q.status_append)
          rd_word[31:24] = status_byte; // R18
      end
      STATUS_OFS:
      begin
        rd_word[7:0]           = status_byte;
        rd_word[STAT_SYNC_BIT] = sync_low;
        rd_word[STAT_SETTLE_BIT] = (state_q == ST_SETTLE);
      end
      default: rd_word = WORD_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ahb_rsp <= '{hrdata: WORD_ZERO, hreadyout: 1'b1, hresp: 1'b0};
    else
    begin
      ahb_rsp.hreadyout <= 1'b1;
      ahb_rsp.hresp     <= 1'b0;
      if (ap_valid && !ahb_req.hwrite)
        ahb_rsp.hrdata <= rd_word;
    end
  end

  // ==========================================================================
  // configuration registers, never touched by sync
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_q <= '{clock_source_sel: CLK_SRC_INT, status_append: 1'b0,
                  parity_enable: 1'b0, fs_word: MODE_FS_RST};
    else if (wr_mode) // R3
    begin
      mode_q.fs_word          <= hwdata[MODE_FS_LSB +: 10];
      mode_q.parity_enable    <= hwdata[MODE_PAR_BIT];
      mode_q.status_append    <= hwdata[MODE_APPEND_BIT];
      mode_q.clock_source_sel <= clk_src_t'({hwdata[MODE_SEL_HI_BIT], hwdata[MODE_SEL_LO_BIT]}); // R11
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg_q <= '{temp_sensor_sel: 1'b0, channel: 4'h0};
    else if (wr_cfg)
    begin
      cfg_q.channel         <= hwdata[CFG_CHAN_LSB +: 4];
      cfg_q.temp_sensor_sel <= hwdata[CFG_TEMP_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gpo_q <= '{gpo_upper_pair_enable: 1'b0, gpo_lower_pair_enable: 1'b0, gpo_level: 4'h0};
    else if (wr_gpo)
    begin
      gpo_q.gpo_level             <= hwdata[GPO_LVL_LSB +: 4];
      gpo_q.gpo_lower_pair_enable <= hwdata[GPO_LO_EN_BIT];
      gpo_q.gpo_upper_pair_enable <= hwdata[GPO_HI_EN_BIT];
    end
  end

  // ==========================================================================
  // conversion sequencer
  logic [23:0] period_clks;
  logic [23:0] period_cnt_q;
  logic [2:0]  settle_cnt_q;
  logic        period_tick;
  logic        conv_done;
  logic        restart;

  assign period_clks = 24'(CLKS_PER_FS_UNIT) * ((mode_q.fs_word == 10'h000) ? 24'h00_0001 : 24'(mode_q.fs_word));
  assign period_tick = (period_cnt_q == period_clks - 24'h00_0001);
  assign restart     = wr_mode || wr_cfg; // R17
  assign conv_done   = period_tick && !sync_low && !restart &&
                       ((state_q == ST_RUN) ||
                        ((state_q == ST_SETTLE) && (settle_cnt_q == 3'(SETTLE_PERIODS - 1)))); // R7

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= ST_START;
    else if (sync_low)
      state_q <= ST_HOLD; // R2
    else if (restart)
      state_q <= ST_START; // R17
    else
      unique case (state_q)
        ST_HOLD:   state_q <= ST_START; // R4
        ST_START:  state_q <= ST_SETTLE; // R6
        ST_SETTLE: if (conv_done) state_q <= ST_RUN;
        ST_RUN:    state_q <= ST_RUN;
      endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_cnt_q <= 24'h00_0000;
      settle_cnt_q <= 3'h0;
    end
    else if (state_q == ST_HOLD || state_q == ST_START)
    begin
      period_cnt_q <= 24'h00_0000;
      settle_cnt_q <= 3'h0;
    end
    else
    begin
      period_cnt_q <= period_tick ? 24'h00_0000 : period_cnt_q + 24'h00_0001;
      if (period_tick && state_q == ST_SETTLE)
        settle_cnt_q <= settle_cnt_q + 3'h1;
    end
  end

  // filter reset while sync is low or after a mode/config write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filter_reset_q <= 1'b1;
      sample_start_q <= 1'b0;
    end
    else
    begin
      filter_reset_q <= sync_low || restart; // R2 R17
      sample_start_q <= (state_q == ST_START) && !sync_low && !restart; // R4
    end
  end

  // ==========================================================================
  // result capture, parity and ready
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_q      <= 24'h00_0000;
      data_chan_q <= 4'h0;
      data_par_q  <= 1'b0;
    end
    else if (conv_done)
    begin
      data_q      <= result_data;
      data_chan_q <= cfg_q.channel; // R18
      data_par_q  <= mode_q.parity_enable && parity24(result_data); // R8
    end
  end

  // a new result wins over a read in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ready_n_q <= 1'b1;
    else if (conv_done)
      ready_n_q <= 1'b0; // R6 R19
    else if (rd_data_evt || sync_low || restart)
      ready_n_q <= 1'b1; // R19
  end

  // ==========================================================================
  // clock source, sensor select and general-purpose outputs
  logic [7:0] osc_div_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clock_source_q       <= CLK_SRC_INT;
      crystal_osc_enable_q <= 1'b0;
      clock_io_oe_q        <= 1'b0;
      temp_sensor_sel_q    <= 1'b0;
    end
    else
    begin
      clock_source_q       <= mode_q.clock_source_sel; // R11
      crystal_osc_enable_q <= (mode_q.clock_source_sel == CLK_SRC_CRYSTAL); // R11
      clock_io_oe_q        <= (mode_q.clock_source_sel == CLK_SRC_INT_OUT); // R12
      temp_sensor_sel_q    <= cfg_q.temp_sensor_sel; // R13
    end
  end

  // internal oscillator stand-in, divided from hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_div_q      <= 8'h00;
      clock_io_out_q <= 1'b0;
    end
    else if (mode_q.clock_source_sel != CLK_SRC_INT_OUT)
    begin
      osc_div_q      <= 8'h00;
      clock_io_out_q <= 1'b0;
    end
    else if (osc_div_q == 8'(OSC_HALF_CYCLES - 1))
    begin
      osc_div_q      <= 8'h00;
      clock_io_out_q <= !clock_io_out_q; // R12
    end
    else
      osc_div_q <= osc_div_q + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gpo_oe_q  <= 4'h0;
      gpo_out_q <= 4'h0;
    end
    else
    begin
      gpo_oe_q  <= {{2{gpo_q.gpo_upper_pair_enable}}, {2{gpo_q.gpo_lower_pair_enable}}}; // R14
      gpo_out_q <= gpo_q.gpo_level; // R15
    end
  end

  // ==========================================================================
  // checks
  logic [31:0] since_start_q;
  logic        first_pend_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      since_start_q <= 32'h0000_0000;
      first_pend_q  <= 1'b0;
    end
    else if (state_q == ST_START)
    begin
      since_start_q <= 32'h0000_0000;
      first_pend_q  <= 1'b1;
    end
    else
    begin
      since_start_q <= since_start_q + 32'h0000_0001;
      if (conv_done)
        first_pend_q <= 1'b0;
    end
  end

  AST_SYNC_HOLDS_RESET: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    sync_low |=> filter_reset_q && ready_n_q)
    else $error("filter not held in reset while sync low");
  AST_SYNC_KEEPS_SETUP: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    sync_low && !wr_pend_q |=> $stable(mode_q) && $stable(cfg_q) && $stable(gpo_q))
    else $error("sync reset altered configuration");
  AST_START_AFTER_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    sync_rise && !restart |=> ##1 sample_start_q)
    else $error("sampling did not restart after sync release");
  AST_READY_FALLS: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    conv_done |=> !ready_n_q && (data_q == $past(result_data)))
    else $error("ready did not fall with new result");
  AST_SETTLE_TIME: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    conv_done && first_pend_q |-> since_start_q == 32'(SETTLE_PERIODS) * 32'(period_clks) - 32'h0000_0001)
    else $error("first result not after full settling time");
  AST_PARITY_EVEN: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    conv_done && mode_q.parity_enable |=> (^{data_q, data_par_q}) == 1'b0)
    else $error("parity bit leaves odd count of ones");
  AST_CLOCK_OUT: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    mode_q.clock_source_sel == CLK_SRC_INT_OUT |=> clock_io_oe_q && !crystal_osc_enable_q)
    else $error("internal clock not driven out");
  AST_SENSOR_SEL: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    wr_cfg |=> ##1 temp_sensor_sel_q == $past(hwdata[CFG_TEMP_BIT], 2))
    else $error("sensor select not applied");
  AST_GPO_PAIRS: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    wr_gpo |=> ##1 gpo_oe_q == {{2{$past(hwdata[GPO_HI_EN_BIT], 2)}}, {2{$past(hwdata[GPO_LO_EN_BIT], 2)}}})
    else $error("output enables not paired");
  AST_GPO_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    wr_gpo |=> ##1 gpo_out_q == $past(hwdata[3:0], 2))
    else $error("output level not driven");
  AST_GPO_READBACK: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    ap_valid && !ahb_req.hwrite && ahb_req.haddr[7:0] == GPOCTL_OFS |=> ahb_rsp.hrdata[3:0] == $past(gpo_in_lvl))
    else $error("readback not from pins");
  AST_WRITE_RESETS: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    restart |=> filter_reset_q && state_q == ST_START)
    else $error("register write did not reset filter");
  AST_READ_CLEARS_READY: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    rd_data_evt && !conv_done |=> ready_n_q)
    else $error("ready not released by data read");

  COV_SYNC_PULSE: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(sync_lvl) ##[4:40] sync_rise);
  COV_FIRST_RESULT: cover property (@(posedge hclk) disable iff (!hresetn)
    conv_done && first_pend_q);
  COV_PARITY_READ: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_data_evt && mode_q.parity_enable && mode_q.status_append && !ready_n_q);

endmodule : adc_sync_parity_gpo_control

// file: dv/pin_side_model.sv
// model of the board around the output pins
// assumes pull-ups on undriven pins and an optional short to ground per pin
`timescale 1ns/1ps
module pin_side_model (
  input  wire logic [3:0] gpo_out,
  input  wire logic [3:0] gpo_oe,
  input  wire logic [3:0] short_low,
  output logic      [3:0] gpo_pin
);
  // ==========================================================================
  // pin levels
  // a shorted pin reads low whatever the driver
  assign gpo_pin = ~short_low & ((gpo_oe & gpo_out) | ~gpo_oe);
endmodule : pin_side_model

// file: dv/adc_sync_parity_gpo_control_tb.sv
// self-checking bench for the converter control block
// assumes the design package and a 50 MHz hclk
`timescale 1ns/1ps
module adc_sync_parity_gpo_control_tb;
  import adc_ctrl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sync_n;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [23:0] res;
  logic [3:0]  short_low, pins, g_out, g_oe;
  ahb_req_t    req;
  ahb_rsp_t    rsp;
  clk_src_t    csrc;
  logic        frst, rdy_n, xtal, io_oe, temp;
  logic        sstart, io_out, io_prev;
  int          num_errors, checks, n, cyc;
  assign req = '{hsel, haddr, htrans, hwrite, HSIZE_WORD, rsp.hreadyout};
  adc_sync_parity_gpo_control #(.CLKS_PER_FS_UNIT(2)) adc_sync_parity_gpo_control_inst (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hwdata(hwdata), .ahb_rsp(rsp),
    .sync_n_pin(sync_n), .result_data(res), .gpo_pin_in(pins), .filter_reset_q(frst),
    .sample_start_q(sstart), .ready_n_q(rdy_n), .clock_source_q(csrc), .crystal_osc_enable_q(xtal),
    .clock_io_out_q(io_out), .clock_io_oe_q(io_oe), .temp_sensor_sel_q(temp),
    .gpo_out_q(g_out), .gpo_oe_q(g_oe));
  pin_side_model pin_side_model_inst (.gpo_out(g_out), .gpo_oe(g_oe), .short_low(short_low), .gpo_pin(pins));

  // ==========================================================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : bus
  task automatic wait_rdy();
    n = 0;
    while (rdy_n !== 1'b0 && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    // a result that never comes counts as a mismatch
    if (n >= 400)
      num_errors++;
  endtask : wait_rdy
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // clock, reset, timeout
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // ==========================================================================
  // tests
  initial
  begin
    {hsel, hwrite, haddr, hwdata, htrans, hresetn} = '0;
    {num_errors, checks, cyc} = '0;
    sync_n = 1'b1;
    res = 24'h80_3C71;
    short_low = 4'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, MODE_OFS, WORD_ZERO);
    chk("mode rst", rd, 32'h0008_0060);
    bus(1'b0, 8'h14, WORD_ZERO);
    chk("unmapped", rd, WORD_ZERO);
    bus(1'b1, CONFIG_OFS, 32'h0001_0005);
    @(posedge hclk);
    #1 chk("temp", temp, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      // parity with status appending, fs 20
      bus(1'b1, MODE_OFS, {12'h000, s[1:0], 2'b11, 6'h00, 10'h014});
      #1 chk("reset on write", frst, 1'b1);
      @(posedge hclk);
      #1 chk("src", csrc, s[1:0]);
      chk("xtal", xtal, s == 0);
      chk("io oe", io_oe, s == 3);
    end
    // internal clock driven out toggles every half period
    io_prev = io_out;
    repeat (OSC_HALF_CYCLES) @(posedge hclk);
    #1 chk("io clk", io_out, !io_prev);
    wait_rdy();
    bus(1'b0, DATA_OFS, WORD_ZERO);
    chk("data", rd & 32'h1FFF_FFFF, {3'b000, ^res, 4'h5, res});
    #1 chk("rdy clr", rdy_n, 1'b1);
    // sync held well past the four cycle minimum
    @(posedge hclk);
    sync_n <= 1'b0;
    repeat (8) @(posedge hclk);
    #1 chk("filt rst", frst, 1'b1);
    chk("rdy hold", rdy_n, 1'b1);
    bus(1'b0, CONFIG_OFS, WORD_ZERO);
    chk("cfg kept", rd, 32'h0001_0005);
    bus(1'b0, STATUS_OFS, WORD_ZERO);
    chk("status", rd, 32'h0000_0195);
    @(posedge hclk);
    sync_n <= 1'b1;
    repeat (6) @(posedge hclk);
    #1 chk("start", sstart, 1'b1);
    wait_rdy();
    chk("settle", n >= 160 && n <= 175, 1'b1);
    short_low <= 4'b0010;
    bus(1'b1, GPOCTL_OFS, 32'h0000_001A);
    @(posedge hclk);
    #1 chk("oe lo", g_oe, 4'b0011);
    chk("out lo", g_out[1:0], 2'b10);
    repeat (6) @(posedge hclk);
    bus(1'b0, GPOCTL_OFS, WORD_ZERO);
    chk("pins", rd, 32'h0000_001C);
    bus(1'b1, GPOCTL_OFS, 32'h0000_0035);
    @(posedge hclk);
    #1 chk("oe all", g_oe, 4'b1111);
    chk("out all", g_out, 4'b0101);
    give_verdict();
  end
endmodule : adc_sync_parity_gpo_control_tb
